// *** tcos_cfg.svh ***
// Constants for the tandem connection overhead source
`ifndef TCOS_CFG_SVH
`define TCOS_CFG_SVH

// ======================================================================
// Register map (byte addresses)
`define TCOS_ADR_CTRL       5'h00
`define TCOS_ADR_STATUS     5'h04
`define TCOS_ADR_TRACE0     5'h08
`define TCOS_ADR_TRACE1     5'h0c
`define TCOS_ADR_TRACE2     5'h10
`define TCOS_ADR_TRACE3     5'h14
`define TCOS_CTRL_EN_BIT    0
`define TCOS_CTRL_RST       32'h0000_0001

// ======================================================================
// Frame layout
`define TCOS_FRAME_BYTES    10'h2fd
`define TCOS_POS_B3         10'h055
`define TCOS_POS_N1         10'h2a8
`define TCOS_MF_FIRST       7'h01
`define TCOS_MF_LAST        7'h4c
`define TCOS_MF_FAS_END     7'h08
`define TCOS_MF_TTI_FIRST   7'h09
`define TCOS_MF_TTI_END     7'h48
`define TCOS_MF_RDI         7'h49
`define TCOS_MF_ODI         7'h4a
`define TCOS_FAS            16'hfffe
`define TCOS_IEC_ZERO       4'h9
`define TCOS_IEC_SF         4'he

// ======================================================================
// Timing
`define TCOS_CLK_PERIOD_NS  8
`define TCOS_MF_PERIOD_US   9500
`define TCOS_DEADLINE_US    20000

// ======================================================================
// Buffering
`define TCOS_FIFO_DEPTH     8
`define TCOS_FIFO_WIDTH     9

`endif

// *** tcos_pkg.sv ***
// Types shared by the tandem connection overhead source
package tcos_pkg;
  typedef logic [7:0] tcos_byte_type;
  typedef logic [3:0] tcos_iec_type;
  typedef logic [6:0] tcos_mf_type;
  typedef logic [9:0] tcos_pos_type;
endpackage

// *** tcos_sink_model.sv ***
// Far-end sink model consuming the outgoing VC-3 stream
`timescale 1ns/100ps
`include "tcos_cfg.svh"
module tcos_sink_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Stream from the source
  input  wire logic       vc_valid_i,
  input  wire logic [7:0] vc_data_in_i,
  input  wire logic       vc_frame_start_in_i,
  output logic            vc_ready_o,
  // Control and capture
  input  wire logic       hold_i,
  output logic            done_o,
  output logic [7:0]      n1_o,
  output logic [7:0]      b3_o,
  output logic [15:0]     bad_o
);
  logic [2:0] tick_q;
  logic [9:0] pos_q;
  wire        take = vc_valid_i && vc_ready_o;
  wire  [9:0] pos = vc_frame_start_in_i ? 10'h000 : pos_q;
  wire        ovh = pos == `TCOS_POS_B3 || pos == `TCOS_POS_N1;
  // ====================================================================
  // One stall in seven so the source FIFO really backs up
  always_ff @(posedge clk_i) begin
    tick_q <= (rst_i || tick_q == 3'h6) ? 3'h0 : tick_q + 3'h1;
    vc_ready_o <= !rst_i && !hold_i && tick_q != 3'h6;
    done_o <= take && pos == `TCOS_POS_N1;
    if (take && pos == `TCOS_POS_N1) n1_o <= vc_data_in_i;
    if (take && pos == `TCOS_POS_B3) b3_o <= vc_data_in_i;
    if (rst_i) begin
      pos_q <= 10'h000;
      bad_o <= 16'h0000;
    end else if (take) begin
      pos_q <= pos + 10'h001;
      if ((!ovh && vc_data_in_i !== pos[7:0]) || (vc_frame_start_in_i && pos_q != 10'h000
          && pos_q != `TCOS_FRAME_BYTES)) bad_o <= bad_o + 16'h0001;
    end
  end
endmodule // tcos_sink_model

// *** tcos_source.sv ***
// VC-3 tandem connection overhead source with its input FIFO
//
// Notes on behaviour
// - Remote defect bit at frame 73 bit 8 follows request within 20 ms.
// - Remote defect bit clears within 20 ms of request clearing.
// - Remote error input copied into N1 bit 5 within 20 ms.
// - Outgoing defect bit at frame 74 bit 7 follows request within 20 ms.
// - Outgoing defect bit clears within 20 ms of request clearing.
// - Outgoing error input copied into N1 bit 6 within 20 ms.
// - N1 bits 7 and 8 form a 76-frame multiframe lasting 9.5 ms.
// - Frames 1 to 8 carry alignment pattern fifteen ones then a zero.
// - Frames 9 to 72 carry the configured transmit trace identifier.
// - Reserved positions of frames 73 to 76 are sent as zero.
// - Even parity over previous incoming frame compared with current B3.
// - Mismatch count 1..8 sent binary in N1 bits 1-4; zero as 1001.
// - Incoming signal fail forces error code 1110.
// - Error code is never all zeros.
// - B3 adjusted whenever N1 is rewritten, keeping path parity sound.
// - New B3 = old B3 prev ^ new B3 prev ^ old N1 prev ^ new N1 prev ^ B3.
// - Defect code one means defect state, zero means normal.
`timescale 1ns/100ps
`include "tcos_cfg.svh"

// ======================================================================
// Synchronous FIFO
module tcos_fifo #(
  parameter int WIDTH = `TCOS_FIFO_WIDTH,
  parameter int DEPTH = `TCOS_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = in_valid_i & in_ready_o;
  wire              pop  = out_valid_o & out_ready_i;
  wire  [AW:0]      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Ready is registered so the fill side never sees a combinational path
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_q       <= '0;
      rd_q       <= '0;
      cnt_q      <= '0;
      in_ready_o <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
      end
      cnt_q      <= cnt_d;
      in_ready_o <= (cnt_d != (AW+1)'(DEPTH));
    end
  end
endmodule // tcos_fifo

// ======================================================================
// Overhead source top
module tcos_source (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [4:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Incoming VC-3 stream
  input  wire logic        vc_valid_i,
  input  wire logic [7:0]  vc_data_in_i,
  input  wire logic        vc_frame_start_in_i,
  output logic             vc_ready_o,
  // Outgoing VC-3 stream
  output logic             vc_valid_o,
  output logic [7:0]       vc_data_out_o,
  output logic             vc_frame_start_out_o,
  input  wire logic        vc_ready_i,
  // Indications from the local sink
  input  wire logic        incoming_signal_fail_i,
  input  wire logic        remote_defect_request_i,
  input  wire logic        remote_error_input_i,
  input  wire logic        outgoing_defect_request_i,
  input  wire logic        outgoing_error_input_i
);

  // ====================================================================
  // Error code encoding
  function automatic tcos_pkg::tcos_iec_type iec_code(
    input logic [7:0] diff,
    input logic       fail
  );
    logic [3:0] n;
    n = '0;
    for (int b = 0; b < 8; b++) begin
      n = n + 4'(diff[b]);
    end
    if (fail) begin
      iec_code = `TCOS_IEC_SF;
    end else if (n == 4'h0) begin
      iec_code = `TCOS_IEC_ZERO;
    end else begin
      iec_code = n;
    end
  endfunction

  // ====================================================================
  // Registers
  logic [31:0]  ctrl_q;
  wire  [127:0] tti_q;
  logic         ack_q;
  logic [31:0]  rdat_q;

  tcos_pkg::tcos_mf_type   mf_q;
  tcos_pkg::tcos_pos_type  pos_q;
  tcos_pkg::tcos_byte_type bip_q;
  tcos_pkg::tcos_byte_type bip_prev_q;
  tcos_pkg::tcos_byte_type b3o_q;
  tcos_pkg::tcos_byte_type b3n_q;
  tcos_pkg::tcos_byte_type n1o_q;
  tcos_pkg::tcos_byte_type n1n_q;
  tcos_pkg::tcos_byte_type b3o_prev_q;
  tcos_pkg::tcos_byte_type b3n_prev_q;
  tcos_pkg::tcos_byte_type n1o_prev_q;
  tcos_pkg::tcos_byte_type n1n_prev_q;
  tcos_pkg::tcos_iec_type  iec_q;
  logic                    out_valid_q;
  logic [7:0]              out_data_q;
  logic                    out_fs_q;

  // ====================================================================
  // FIFO in the data path
  logic       f_valid;
  logic [8:0] f_data;
  logic       in_ready;
  wire        pop = f_valid & (~out_valid_q | vc_ready_i);

  tcos_fifo #(
    .WIDTH (`TCOS_FIFO_WIDTH),
    .DEPTH (`TCOS_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (vc_valid_i),
    .in_data_i   ({vc_frame_start_in_i, vc_data_in_i}),
    .in_ready_o  (in_ready),
    .out_valid_o (f_valid),
    .out_data_o  (f_data),
    .out_ready_i (pop)
  );

  assign vc_ready_o = in_ready;

  // ====================================================================
  // Byte position and multiframe decode
  wire       byte_fs  = f_data[8];
  wire [7:0] byte_in  = f_data[7:0];
  wire [9:0] cur_pos  = byte_fs ? 10'h000 : pos_q;
  wire       at_b3    = (cur_pos == `TCOS_POS_B3);
  wire       at_n1    = (cur_pos == `TCOS_POS_N1);
  wire       en       = ctrl_q[`TCOS_CTRL_EN_BIT];
  wire [6:0] mf_next  = (mf_q == `TCOS_MF_LAST) ? `TCOS_MF_FIRST : mf_q + 7'h01;

  // Alignment and trace bits picked by shifting; the MSB leaves first
  wire [6:0]   fas_sh  = 7'((mf_q - 7'h01) << 1);
  wire [6:0]   tti_sh  = 7'((mf_q - `TCOS_MF_TTI_FIRST) << 1);
  wire [15:0]  fas_w   = `TCOS_FAS << fas_sh[3:0];
  wire [127:0] tti_w   = tti_q << tti_sh;
  wire         is_fas  = (mf_q <= `TCOS_MF_FAS_END);
  wire         is_tti  = (mf_q >= `TCOS_MF_TTI_FIRST) && (mf_q <= `TCOS_MF_TTI_END);
  wire         is_rdi  = (mf_q == `TCOS_MF_RDI);
  wire         is_odi  = (mf_q == `TCOS_MF_ODI);

  logic [1:0] mf_bits;
  always_comb begin
    mf_bits = 2'b00;
    if (is_fas) begin
      mf_bits = fas_w[15:14];
    end else if (is_tti) begin
      mf_bits = tti_w[127:126];
    end else if (is_rdi) begin
      mf_bits = {1'b0, remote_defect_request_i};
    end else if (is_odi) begin
      mf_bits = {outgoing_defect_request_i, 1'b0};
    end
  end

  // N1 from the MSB: code, remote error, outgoing error, bits 7 and 8
  wire [7:0] n1_new = en ? {iec_q, remote_error_input_i,
                            outgoing_error_input_i,
                            mf_bits} : byte_in;
  wire [7:0] b3_new = b3o_prev_q ^ b3n_prev_q ^ n1o_prev_q ^ n1n_prev_q
                      ^ byte_in;
  wire [7:0] byte_out = at_n1 ? n1_new : (at_b3 ? b3_new : byte_in);

  // ====================================================================
  // Stream processing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_q       <= '0;
      mf_q        <= `TCOS_MF_FIRST;
      bip_q       <= '0;
      bip_prev_q  <= '0;
      iec_q       <= `TCOS_IEC_ZERO;
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
      out_fs_q    <= 1'b0;
    end else begin
      if (pop) begin
        out_valid_q <= 1'b1;
        out_data_q  <= byte_out;
        out_fs_q    <= byte_fs;
        pos_q       <= 10'(cur_pos + 10'h001);
        if (byte_fs) begin
          mf_q       <= mf_next;
          bip_prev_q <= bip_q;
          bip_q      <= byte_in;
        end else begin
          bip_q      <= bip_q ^ byte_in;
        end
        if (at_b3) begin
          iec_q <= iec_code(bip_prev_q ^ byte_in, incoming_signal_fail_i);
        end
      end else if (vc_ready_i) begin
        out_valid_q <= 1'b0;
      end
    end
  end

  // Previous-frame copies feeding the parity compensation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      b3o_q      <= '0;
      b3n_q      <= '0;
      n1o_q      <= '0;
      n1n_q      <= '0;
      b3o_prev_q <= '0;
      b3n_prev_q <= '0;
      n1o_prev_q <= '0;
      n1n_prev_q <= '0;
    end else if (pop) begin
      if (byte_fs) begin
        b3o_prev_q <= b3o_q;
        b3n_prev_q <= b3n_q;
        n1o_prev_q <= n1o_q;
        n1n_prev_q <= n1n_q;
      end
      if (at_b3) begin
        b3o_q <= byte_in;
        b3n_q <= b3_new;
      end
      if (at_n1) begin
        n1o_q <= byte_in;
        n1n_q <= n1_new;
      end
    end
  end

  assign vc_valid_o           = out_valid_q;
  assign vc_data_out_o        = out_data_q;
  assign vc_frame_start_out_o = out_fs_q;

  // ====================================================================
  // Wishbone slave
  wire        req     = cyc_i & stb_i & ~ack_q;
  wire        wr      = req & we_i;
  wire [31:0] wmask   = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  wire [31:0] status  = {16'h0000, 1'b0, mf_q, iec_q, 3'b000, incoming_signal_fail_i};

  logic [31:0] rd_mux;
  always_comb begin
    case (adr_i)
      `TCOS_ADR_CTRL:   rd_mux = ctrl_q;
      `TCOS_ADR_STATUS: rd_mux = status;
      `TCOS_ADR_TRACE0: rd_mux = tti_q[127:96];
      `TCOS_ADR_TRACE1: rd_mux = tti_q[95:64];
      `TCOS_ADR_TRACE2: rd_mux = tti_q[63:32];
      `TCOS_ADR_TRACE3: rd_mux = tti_q[31:0];
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= '0;
      ctrl_q <= `TCOS_CTRL_RST;
    end else begin
      ack_q  <= req;
      rdat_q <= req ? rd_mux : 32'h0000_0000;
      if (wr && adr_i == `TCOS_ADR_CTRL) begin
        ctrl_q <= ((ctrl_q & ~wmask) | (dat_i & wmask)) & 32'h0000_0001;
      end
    end
  end

  // Trace words, one per generate step; each word owns its flops, one driver per slice
  for (genvar w = 0; w < 4; w++) begin : g_tti
    wire         hit = wr && (adr_i == 5'(`TCOS_ADR_TRACE0 + 4 * w));
    logic [31:0] word_q;
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        word_q <= '0;
      end else if (hit) begin
        word_q <= (word_q & ~wmask) | (dat_i & wmask);
      end
    end
    assign tti_q[127-32*w -: 32] = word_q;
  end

  assign ack_o = ack_q;
  assign dat_o = rdat_q;

endmodule // tcos_source

// *** tcos_source_sva.sv ***
// Checker for the tandem connection overhead source ports
`timescale 1ns/100ps
`include "tcos_cfg.svh"
module tcos_source_sva (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Wishbone
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [4:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // Streams and indications
  input wire logic        vc_valid_o,
  input wire logic [7:0]  vc_data_out_o,
  input wire logic        vc_frame_start_out_o,
  input wire logic        vc_ready_i,
  input wire logic        remote_error_input_i,
  input wire logic        outgoing_error_input_i
);
  logic [9:0]  pos_q;
  logic [6:0]  mf_q;
  logic        seen_q;
  logic        en_q;
  wire         acc = vc_valid_o && vc_ready_i;
  wire         at_n1 = acc && !vc_frame_start_out_o && pos_q == `TCOS_POS_N1;
  wire [15:0]  fas_sh = 16'(`TCOS_FAS << (2 * (mf_q - 7'h01)));
  wire         ctl_wr = cyc_i && stb_i && we_i && ack_o && adr_i == `TCOS_ADR_CTRL && sel_i[0];
  // ====================================================================
  // Output framing tracker, numbered as the frames leave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_q <= 10'h000;
      mf_q <= `TCOS_MF_FIRST;
      seen_q <= 1'b0;
      en_q <= 1'b1;
    end else begin
      if (acc) pos_q <= vc_frame_start_out_o ? 10'h001 : pos_q + 10'h001;
      if (acc && vc_frame_start_out_o) mf_q <= (mf_q == `TCOS_MF_LAST) ? `TCOS_MF_FIRST : mf_q + 7'h01;
      if (acc && vc_frame_start_out_o) seen_q <= 1'b1;
      if (ctl_wr) en_q <= dat_i[0];
    end
  end
  // ====================================================================
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence wb_take; cyc_i && stb_i && !ack_o; endsequence
  sequence ack_pulse; ack_o ##1 !ack_o; endsequence
  ack_reply_a: assert property (wb_take |=> ack_pulse) else $error("ack not one cycle after take");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i && !ack_o)) else $error("stray ack");
  dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
  out_hold_a: assert property (vc_valid_o && !vc_ready_i |=> vc_valid_o && $stable(vc_data_out_o)
    && $stable(vc_frame_start_out_o)) else $error("output changed while stalled");
  frame_len_a: assert property (acc && vc_frame_start_out_o && seen_q |-> pos_q == `TCOS_FRAME_BYTES)
    else $error("frame length wrong");
  iec_nonzero_a: assert property (at_n1 && en_q |-> vc_data_out_o[7:4] != 4'h0)
    else $error("all zero error code");
  fas_bits_a: assert property (at_n1 && en_q && mf_q <= `TCOS_MF_FAS_END |->
    vc_data_out_o[1:0] == fas_sh[15:14]) else $error("alignment bits wrong");
  rsv_zero_a: assert property (at_n1 && en_q && mf_q >= `TCOS_MF_RDI |-> (mf_q == `TCOS_MF_RDI ?
    !vc_data_out_o[1] : mf_q == `TCOS_MF_ODI ? !vc_data_out_o[0] : vc_data_out_o[1:0] == 2'b00))
    else $error("reserved bit set");
  err_bits_a: assert property (at_n1 && en_q |-> vc_data_out_o[3:2] ==
    {remote_error_input_i, outgoing_error_input_i}) else $error("error bits wrong");
endmodule // tcos_source_sva

bind tcos_source tcos_source_sva tcos_source_sva_inst (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .vc_valid_o(vc_valid_o), .vc_data_out_o(vc_data_out_o),
  .vc_frame_start_out_o(vc_frame_start_out_o), .vc_ready_i(vc_ready_i),
  .remote_error_input_i(remote_error_input_i), .outgoing_error_input_i(outgoing_error_input_i));

// *** tcos_source_tb.sv ***
// Self-checking bench for the tandem connection overhead source
`timescale 1ns/100ps
`include "tcos_cfg.svh"
module tcos_source_tb;
  localparam int NF = 80;
  localparam logic [127:0] TRACE = 128'h8000_0001_c3a5_5a3c_0f0f_f0f0_1234_abcd;
  // ====================================================================
  // Signals
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
  logic [4:0]  adr_i = 5'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic        vc_valid_i = 1'b0, vc_frame_start_in_i = 1'b0, vc_ready_o;
  logic [7:0]  vc_data_in_i = 8'h00, vc_data_out_o, sink_n1, sink_b3;
  logic        vc_valid_o, vc_frame_start_out_o, vc_ready_i, sink_done, hold_i = 1'b0;
  logic        fail_i = 1'b0, rdi_i = 1'b0, rei_i = 1'b0, odi_i = 1'b0, oei_i = 1'b0;
  logic [15:0] sink_bad;
  logic [7:0]  exp_n1 [NF], exp_b3 [NF];
  int          err_count = 0, num_checks = 0, cycles = 0, hold_n = 0;
  always #4 clk_i = ~clk_i;
  tcos_source tcos_source_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .vc_valid_i(vc_valid_i), .vc_data_in_i(vc_data_in_i), .vc_frame_start_in_i(vc_frame_start_in_i),
    .vc_ready_o(vc_ready_o), .vc_valid_o(vc_valid_o), .vc_data_out_o(vc_data_out_o),
    .vc_frame_start_out_o(vc_frame_start_out_o), .vc_ready_i(vc_ready_i),
    .incoming_signal_fail_i(fail_i), .remote_defect_request_i(rdi_i),
    .remote_error_input_i(rei_i), .outgoing_defect_request_i(odi_i), .outgoing_error_input_i(oei_i));
  tcos_sink_model tcos_sink_model_inst (.clk_i(clk_i), .rst_i(rst_i), .vc_valid_i(vc_valid_o),
    .vc_data_in_i(vc_data_out_o), .vc_frame_start_in_i(vc_frame_start_out_o),
    .vc_ready_o(vc_ready_i), .hold_i(hold_i), .done_o(sink_done), .n1_o(sink_n1),
    .b3_o(sink_b3), .bad_o(sink_bad));
  // ====================================================================
  // Tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb_cyc(input logic [4:0] a, input logic w, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] q);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wb_rd(input logic [4:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] q;
    wb_cyc(a, 1'b0, 32'h0, 4'hf, q);
    check(nm, q, exp);
  endtask
  task automatic put(input logic [7:0] b, input logic fs);
    vc_data_in_i <= b;
    vc_frame_start_in_i <= fs;
    vc_valid_i <= 1'b1;
    do @(posedge clk_i); while (vc_ready_o !== 1'b1);
  endtask
  task automatic send_all();
    logic [7:0] px, pb3o, pb3n, pn1o, pn1n, b3o, n1n, mask, q;
    logic [1:0] pr;
    logic [3:0] iec;
    int c, mf;
    {px, pb3o, pb3n, pn1o, pn1n} = 40'h0;
    for (int p = 0; p < 765; p++) if (p != 85 && p != 680) px ^= p[7:0];
    for (int k = 0; k < NF; k++) begin
      if (k == 30 || k == 32) begin
        vc_valid_i <= 1'b0;
        wb_cyc(`TCOS_ADR_CTRL, 1'b1, {31'h0, k == 32}, 4'h1, q);
      end
      c = k % 9;
      mask = 8'((9'h001 << c) - 9'h001);
      b3o = px ^ 8'h3c ^ pb3o ^ mask;
      fail_i <= (k == 0 || k == 20);
      {rdi_i, odi_i} <= {2{k >= 60}};
      {rei_i, oei_i} <= {k[0], k[1]};
      mf = (k + 1) % 76 + 1;
      iec = (k == 0 || k == 20) ? `TCOS_IEC_SF : (c == 0) ? `TCOS_IEC_ZERO : 4'(c);
      if (mf <= 8) pr = 2'(`TCOS_FAS >> (16 - 2 * mf));
      else if (mf <= 72) pr = 2'(TRACE >> (144 - 2 * mf));
      else pr = {mf == 74 && k >= 60, mf == 73 && k >= 60};
      n1n = (k == 30 || k == 31) ? 8'h3c : {iec, k[0], k[1], pr};
      exp_n1[k] = n1n;
      exp_b3[k] = pb3o ^ pb3n ^ pn1o ^ pn1n ^ b3o;
      {pb3o, pb3n, pn1o, pn1n} = {b3o, exp_b3[k], 8'h3c, n1n};
      for (int p = 0; p < 765; p++) begin
        put((p == 85) ? b3o : (p == 680) ? 8'h3c : p[7:0], p == 0);
        if (k == 50 && p == 290) hold_i <= 1'b1;
      end
    end
    vc_valid_i <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ====================================================================
  // Long stall fills the FIFO; watchdog
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      err_count++;
      print_verdict();
    end
    if (hold_i && ++hold_n == 30) begin
      check("ready full", {31'h0, vc_ready_o}, 32'h0);
      hold_i <= 1'b0;
    end
  end
  // ====================================================================
  // Main sequence
  initial begin
    logic [31:0] q;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_rd(`TCOS_ADR_CTRL, 32'h1, "ctrl reset");
    wb_rd(`TCOS_ADR_STATUS, 32'h190, "status reset");
    wb_cyc(`TCOS_ADR_CTRL, 1'b1, 32'h0, 4'he, q);
    wb_rd(`TCOS_ADR_CTRL, 32'h1, "ctrl masked");
    wb_cyc(5'h18, 1'b1, 32'hffff_ffff, 4'hf, q);
    wb_rd(5'h18, 32'h0, "unmapped");
    for (int i = 0; i < 4; i++) begin
      wb_rd(`TCOS_ADR_TRACE0 + 5'(4 * i), 32'h0, "trace reset");
      wb_cyc(`TCOS_ADR_TRACE0 + 5'(4 * i), 1'b1, TRACE[127 - 32 * i -: 32], 4'hf, q);
      wb_rd(`TCOS_ADR_TRACE0 + 5'(4 * i), TRACE[127 - 32 * i -: 32], "trace");
    end
    fork
      send_all();
      for (int j = 0; j < NF; j++) begin
        @(posedge clk_i iff sink_done);
        check("n1", {24'h0, sink_n1}, {24'h0, exp_n1[j]});
        check("b3", {24'h0, sink_b3}, {24'h0, exp_b3[j]});
      end
    join
    wb_rd(`TCOS_ADR_STATUS, 32'h570, "status end");
    check("sink", {16'h0, sink_bad}, 32'h0);
    print_verdict();
  end
endmodule // tcos_source_tb
